// ==== logic/fac_pkg.sv ====
/*
 * Shared constants and types for the clocked digital side of a two-step
 * flash converter: result layout, stage counts, clock timing limits.
 * Assumes a 100 MHz system clock that samples the converter clock pin.
 */
package fac_pkg;

    // System clock
    localparam int unsigned SYS_CLK_MHZ   = 100;
    localparam int unsigned SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;

    // Converter clock limits, figures in ns
    localparam int unsigned T_PERIOD_MIN_NS = 1000;
    localparam int unsigned T_PHASE_MIN_NS  = 500;
    localparam int unsigned T_PHASE_MAX_NS  = 500000;
    // Least times round up, longest times round down
    localparam int unsigned PERIOD_MIN_CYC =
        (T_PERIOD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned PHASE_MIN_CYC =
        (T_PHASE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned PHASE_MAX_CYC = T_PHASE_MAX_NS / SYS_PERIOD_NS;
    localparam int unsigned PHASE_CNT_W   = 17;

    // Result layout
    localparam int unsigned RES_W      = 10;
    localparam int unsigned COARSE_W   = 4;
    localparam int unsigned FINE_W     = 6;
    localparam int unsigned N_COARSE   = 15;
    localparam int unsigned N_FINE     = 67;
    localparam int unsigned FCNT_W     = 7;
    localparam int unsigned FINE_OFS   = 2;   // Fine comparators below range
    localparam int unsigned N_CODES    = 1024;
    localparam logic [9:0]  RES_ZERO   = 10'h000;
    localparam logic [9:0]  RES_FULL   = 10'h3ff;
    localparam int unsigned PIPE_STAGES = 2;
    localparam int unsigned FIFO_DEPTH  = 4;

    // One conversion result with its flag
    typedef struct packed {
        logic             over_range;
        logic [RES_W-1:0] bits;
    } fac_result_t;

    // Conversion sequencing states
    typedef enum logic [1:0] {
        FAC_ST_IDLE   = 2'b00,
        FAC_ST_SAMPLE = 2'b01,
        FAC_ST_FINE   = 2'b10
    } fac_state_t;

endpackage : fac_pkg

// ==== logic/fac_fifo.sv ====
/*
 * Small synchronous FIFO for conversion results, valid/ready both sides.
 * Assumes one clock, active-low asynchronous reset; DEPTH a power of two.
 */
`timescale 1ns/1ps
module fac_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    // Fill side
    input  wire logic                       in_valid_i,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            in_ready_o,
    // Drain side
    output logic                            out_valid_o,
    output logic [WIDTH-1:0]                out_data_o,
    input  wire logic                       out_ready_i,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      level_o
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [LW-1:0]    level_q;
    logic             push;
    logic             pop;

    // Honest full and empty from the level count
    assign in_ready_o  = (level_q != LW'(DEPTH));
    assign out_valid_o = (level_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign level_o     = level_q;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage, no reset needed on data
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers and level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PW'(1);
            end
            if (push && !pop) begin
                level_q <= level_q + LW'(1);
            end else if (pop && !push) begin
                level_q <= level_q - LW'(1);
            end
        end
    end

endmodule : fac_fifo

// ==== logic/fac_conv.sv ====
/*
 * Clocked digital side of a 10-bit two-step flash converter: phase
 * generation from the converter clock, coarse/fine encoding, two-stage
 * output pipeline, output enable and a buffered result stream.
 * Assumes all inputs, the converter clock among them, are synchronous to
 * clock_i; comparator outputs arrive as thermometer vectors.
 */
`timescale 1ns/1ps
module fac_conv #(
    parameter int unsigned FIFO_DEPTH    = fac_pkg::FIFO_DEPTH,
    parameter int unsigned PHASE_MAX_CYC = fac_pkg::PHASE_MAX_CYC
) (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_n_i,
    // Converter clock and output enable from the partner
    input  wire logic                          conv_clk_i,
    input  wire logic                          oe_n_i,
    // Comparator thermometer outputs
    input  wire logic [fac_pkg::N_COARSE-1:0]  coarse_therm_i,
    input  wire logic [fac_pkg::N_FINE-1:0]    fine_therm_i,
    // Result pins
    output logic [fac_pkg::RES_W-1:0]          conv_result_bits_o,
    output logic                               conv_result_oe_o,
    output logic                               over_range_flag_o,
    // Internal phases and status
    output logic                               phase_balance_o,
    output logic                               phase_sample_o,
    output logic                               conv_skip_o,
    output logic                               clk_timing_err_o,
    // Buffered result stream
    output logic                               res_valid_o,
    output fac_pkg::fac_result_t               res_data_o,
    input  wire logic                          res_ready_i
);
    localparam int unsigned LW = $clog2(FIFO_DEPTH+1);

    fac_pkg::fac_state_t                state_q;
    logic                               clk_q;
    logic                               rise;
    logic                               fall;
    logic                               accept;
    logic [fac_pkg::COARSE_W-1:0]       coarse_q;
    logic                               coarse_vld_q;
    fac_pkg::fac_result_t               enc_q;
    logic                               enc_vld_q;
    fac_pkg::fac_result_t               s1_q;
    logic                               s1_vld_q;
    fac_pkg::fac_result_t               s2_q;
    logic                               fifo_ready;
    logic [LW-1:0]                      fifo_level;
    logic [fac_pkg::PHASE_CNT_W-1:0]    phase_cnt_q;
    logic [fac_pkg::PHASE_CNT_W-1:0]    hi_len_q;
    logic                               phase_err;

    // Count of set comparator outputs in a thermometer vector
    function automatic logic [fac_pkg::FCNT_W-1:0] therm_count(
        input logic [fac_pkg::N_FINE-1:0] therm
    );
        logic [fac_pkg::FCNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < fac_pkg::N_FINE; i++) begin
            n = n + fac_pkg::FCNT_W'(therm[i]);
        end
        return n;
    endfunction : therm_count

    // Coarse range plus fine offset, clamped into the code span
    function automatic fac_pkg::fac_result_t encode(
        input logic [fac_pkg::COARSE_W-1:0] coarse,
        input logic [fac_pkg::FCNT_W-1:0]   fcnt
    );
        fac_pkg::fac_result_t r;
        int                   v;
        v = int'(coarse) * (1 << fac_pkg::FINE_W) + int'(fcnt)
            - int'(fac_pkg::FINE_OFS);
        r.over_range = 1'b0;
        if (v < 0) begin
            r.bits = fac_pkg::RES_ZERO;
        end else if (v >= int'(fac_pkg::N_CODES)) begin
            r.bits       = fac_pkg::RES_FULL;
            r.over_range = 1'b1;
        end else begin
            r.bits = fac_pkg::RES_W'(v);
        end
        return r;
    endfunction : encode

    // Edges of the converter clock; the pin is already synchronous
    assign rise = conv_clk_i && !clk_q;
    assign fall = !conv_clk_i && clk_q;
    // Refuse a new sample unless every result in flight has a FIFO slot,
    // so back-pressure from the stream never loses a finished result
    assign accept = rise && (int'(fifo_level) + int'(coarse_vld_q)
                    + int'(enc_vld_q) + int'(s1_vld_q) + 1
                    <= int'(FIFO_DEPTH));

    // Phase outputs follow the clock level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_q           <= 1'b0;
            phase_balance_o <= 1'b0;
            phase_sample_o  <= 1'b1;
        end else begin
            clk_q           <= conv_clk_i;
            phase_balance_o <= conv_clk_i;
            phase_sample_o  <= !conv_clk_i;
        end
    end

    // Sequencer: sample ends on rise, fine pass closes on fall
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= fac_pkg::FAC_ST_IDLE;
        end else begin
            case (state_q)
                fac_pkg::FAC_ST_IDLE: begin
                    // First rise after reset comes without a seen fall
                    if (accept) begin
                        state_q <= fac_pkg::FAC_ST_FINE;
                    end else if (fall) begin
                        state_q <= fac_pkg::FAC_ST_SAMPLE;
                    end
                end
                fac_pkg::FAC_ST_SAMPLE: begin
                    if (accept) begin
                        state_q <= fac_pkg::FAC_ST_FINE;
                    end else if (rise) begin
                        state_q <= fac_pkg::FAC_ST_IDLE;
                    end
                end
                fac_pkg::FAC_ST_FINE: begin
                    if (fall) begin
                        state_q <= fac_pkg::FAC_ST_SAMPLE;
                    end
                end
                default: begin
                    state_q <= fac_pkg::FAC_ST_IDLE;
                end
            endcase
        end
    end

    // Coarse pass captured at the end of the sample phase
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coarse_q     <= '0;
            coarse_vld_q <= 1'b0;
        end else if (accept) begin
            coarse_q     <= fac_pkg::COARSE_W'(therm_count(
                            fac_pkg::N_FINE'(coarse_therm_i)));
            coarse_vld_q <= 1'b1;
        end else if (fall) begin
            coarse_vld_q <= 1'b0;
        end
    end

    // Fine pass on the selected range, closed at the end of balance
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_q     <= '0;
            enc_vld_q <= 1'b0;
        end else if (fall && coarse_vld_q) begin
            enc_q     <= encode(coarse_q, therm_count(fine_therm_i));
            enc_vld_q <= 1'b1;
        end else if (rise) begin
            enc_vld_q <= 1'b0;
        end
    end

    // Two output stages, both advanced by the converter clock rise
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q     <= '0;
            s1_vld_q <= 1'b0;
            s2_q     <= '0;
        end else if (rise) begin
            s1_vld_q <= enc_vld_q;
            if (enc_vld_q) begin
                s1_q <= enc_q;
            end
            if (s1_vld_q) begin
                s2_q <= s1_q;
            end
        end
    end

    // Pins straight from the second stage
    assign conv_result_bits_o = s2_q.bits;
    assign over_range_flag_o  = s2_q.over_range;
    // Enable is combinational on purpose: it must not wait for a clock
    assign conv_result_oe_o   = !oe_n_i;

    // Refused sample edges reported as a pulse
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_skip_o <= 1'b0;
        end else begin
            conv_skip_o <= rise && !accept;
        end
    end

    // Phase length monitor; counter saturates just past the limit.
    // Period is judged rise to rise: this low plus the last high length;
    // after reset the first period counts from the release only
    assign phase_err = ((rise || fall)
                        && (int'(phase_cnt_q) + 1
                            < int'(fac_pkg::PHASE_MIN_CYC)))
                    || (int'(phase_cnt_q) == int'(PHASE_MAX_CYC))
                    || (rise && (int'(phase_cnt_q) + int'(hi_len_q) + 1
                        < int'(fac_pkg::PERIOD_MIN_CYC)));
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_cnt_q      <= '0;
            hi_len_q         <= '0;
            clk_timing_err_o <= 1'b0;
        end else begin
            clk_timing_err_o <= phase_err;
            if (rise || fall) begin
                phase_cnt_q <= '0;
            end else if (int'(phase_cnt_q) <= int'(PHASE_MAX_CYC)) begin
                phase_cnt_q <= phase_cnt_q + fac_pkg::PHASE_CNT_W'(1);
            end
            if (fall) begin
                hi_len_q <= phase_cnt_q + fac_pkg::PHASE_CNT_W'(1);
            end
        end
    end

    // Result stream buffer, filled as results reach the second stage
    fac_fifo #(
        .WIDTH ($bits(fac_pkg::fac_result_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (rise && s1_vld_q),
        .in_data_i   (s1_q),
        .in_ready_o  (fifo_ready),
        .out_valid_o (res_valid_o),
        .out_data_o  (res_data_o),
        .out_ready_i (res_ready_i),
        .level_o     (fifo_level)
    );

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_phase_split: assert property (
        rise |=> phase_balance_o && !phase_sample_o)
        else $error("balance phase not entered on clock rise");

    chk_sample_fix: assert property (
        accept |=> coarse_vld_q && state_q == fac_pkg::FAC_ST_FINE)
        else $error("sample not fixed on clock rise");

    chk_fine_attach: assert property (
        fall && coarse_vld_q |=> enc_vld_q && !coarse_vld_q)
        else $error("fine pass not closed at end of balance");

    chk_stage_two: assert property (
        rise && s1_vld_q |=> s2_q == $past(s1_q))
        else $error("second stage did not take first stage");

    chk_stage_hold: assert property (
        !rise |=> $stable(s1_q) && $stable(s2_q))
        else $error("output stages moved without clock rise");

    chk_flag_full: assert property (
        over_range_flag_o |-> conv_result_bits_o == fac_pkg::RES_FULL)
        else $error("over-range flag with non full-scale bits");

    chk_seg_code: assert property (
        fall && coarse_vld_q && coarse_q != 4'h0 && coarse_q != 4'hf
        |=> enc_q.bits[9:6] == $past(coarse_q)
            || enc_q.bits[9:6] == $past(coarse_q) + 4'h1
            || enc_q.bits[9:6] == $past(coarse_q) - 4'h1)
        else $error("coarse segment lost in encoding");

    chk_oe_drive: assert property (
        conv_result_oe_o == !oe_n_i)
        else $error("result enable does not follow low input");

    chk_no_overflow: assert property (
        rise && s1_vld_q |-> fifo_ready)
        else $error("result reached a full buffer");

endmodule : fac_conv

// ==== verification/fac_capture_model.sv ====
/*
 * Capture-side partner: makes the converter clock pulse by pulse and
 * takes buffered results into a queue for the bench to inspect.
 * Assumes the bench asks for one clock period at a time via go_i.
 */
`timescale 1ns/1ps
module fac_capture_model (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    // Pulse request and shape
    input  wire logic                 go_i,
    input  wire logic [7:0]           hi_cyc_i,
    input  wire logic [7:0]           lo_cyc_i,
    input  wire logic                 stall_i,
    // Converter side
    output logic                      conv_clk_o,
    output logic                      busy_o,
    input  wire logic                 res_valid_i,
    input  wire fac_pkg::fac_result_t res_data_i,
    output logic                      res_ready_o
);
    logic [8:0]           cnt_q;
    fac_pkg::fac_result_t got[$];

    // One high then one low phase per request; idles low between
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_clk_o <= 1'b0;
            busy_o     <= 1'b0;
            cnt_q      <= 9'h000;
        end else if (!busy_o) begin
            if (go_i) begin
                conv_clk_o <= 1'b1;
                busy_o     <= 1'b1;
                cnt_q      <= {1'b0, hi_cyc_i} - 9'h001;
            end
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end else if (conv_clk_o) begin
            conv_clk_o <= 1'b0;
            cnt_q      <= {1'b0, lo_cyc_i} - 9'h001;
        end else begin
            busy_o <= 1'b0;
        end
    end

    // Sink may stall to back the buffer up
    assign res_ready_o = !stall_i;

    // Take each word as it is handed over
    always @(posedge clock_i) begin
        if (rst_n_i && res_valid_i && res_ready_o) begin
            got.push_back(res_data_i);
        end
    end
endmodule : fac_capture_model

// ==== verification/fac_conv_tb_top.sv ====
/*
 * Self-checking bench for the converter's clocked side: codes,
 * pipeline latency, output enable, buffering and clock limits.
 * Assumes the capture model in its own file drives the converter clock.
 */
`timescale 1ns/1ps
module fac_conv_tb_top;
    // Drive
    logic                            clock_i = 1'b0;
    logic                            rst_n_i = 1'b0;
    logic                            oe_n_i  = 1'b0;
    logic                            go      = 1'b0;
    logic                            stall   = 1'b0;
    logic [7:0]                      hi_cyc  = 8'h3c;
    logic [fac_pkg::N_COARSE-1:0]    coarse_therm_i = '0;
    logic [fac_pkg::N_FINE-1:0]      fine_therm_i   = '0;
    // Observe
    logic [9:0]                      conv_result_bits_o;
    logic                            conv_result_oe_o;
    logic                            over_range_flag_o;
    logic                            phase_balance_o;
    logic                            phase_sample_o;
    logic                            conv_skip_o;
    logic                            clk_timing_err_o;
    logic                            res_valid_o;
    logic                            res_ready;
    logic                            conv_clk;
    logic                            busy;
    fac_pkg::fac_result_t            res_data_o;
    logic                            skip_seen = 1'b0;
    logic                            err_seen  = 1'b0;
    fac_pkg::fac_result_t            exp_q[$];
    int                              bad_count = 0;
    int                              tests_run = 0;

    always #5 clock_i = ~clock_i;

    // Short phase limit keeps a stuck clock cheap to detect
    fac_conv #(.FIFO_DEPTH(4), .PHASE_MAX_CYC(200)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .conv_clk_i(conv_clk),
        .oe_n_i(oe_n_i), .coarse_therm_i(coarse_therm_i),
        .fine_therm_i(fine_therm_i),
        .conv_result_bits_o(conv_result_bits_o),
        .conv_result_oe_o(conv_result_oe_o),
        .over_range_flag_o(over_range_flag_o),
        .phase_balance_o(phase_balance_o),
        .phase_sample_o(phase_sample_o), .conv_skip_o(conv_skip_o),
        .clk_timing_err_o(clk_timing_err_o), .res_valid_o(res_valid_o),
        .res_data_o(res_data_o), .res_ready_i(res_ready));

    fac_capture_model u_model (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .go_i(go),
        .hi_cyc_i(hi_cyc), .lo_cyc_i(8'h3c), .stall_i(stall),
        .conv_clk_o(conv_clk), .busy_o(busy), .res_valid_i(res_valid_o),
        .res_data_i(res_data_o), .res_ready_o(res_ready));

    // Pulses last one cycle, so latch them for later checks
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            skip_seen <= 1'b0;
            err_seen  <= 1'b0;
        end else begin
            if (conv_skip_o === 1'b1) skip_seen <= 1'b1;
            if (clk_timing_err_o === 1'b1) err_seen <= 1'b1;
        end
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    function automatic fac_pkg::fac_result_t expect_res(input int c,
                                                        input int f);
        fac_pkg::fac_result_t r;
        int                   v;
        v = c * 64 + f - int'(fac_pkg::FINE_OFS);
        r.over_range = (v > 1023);
        if (v < 0) r.bits = fac_pkg::RES_ZERO;
        else if (v > 1023) r.bits = fac_pkg::RES_FULL;
        else r.bits = v[9:0];
        return r;
    endfunction : expect_res

    task automatic do_reset();
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        #1;
        check({1'b0, conv_result_bits_o}, 11'h000);
        check({7'h0, over_range_flag_o, phase_sample_o, phase_balance_o,
               res_valid_o}, 11'h004);
        @(posedge clock_i) rst_n_i <= 1'b1;
        u_model.got.delete();
        exp_q.delete();
        // Long low start keeps the first rise inside the clock limits
        repeat (120) @(posedge clock_i);
    endtask : do_reset

    task automatic set_in(input int c, input int f);
        @(posedge clock_i);
        coarse_therm_i <= {fac_pkg::N_COARSE{1'b1}} >> (15 - c);
        fine_therm_i   <= {fac_pkg::N_FINE{1'b1}} >> (67 - f);
        exp_q.push_back(expect_res(c, f));
    endtask : set_in

    // One converter clock period; optionally watch the phases
    task automatic pulse(input bit ph);
        int n;
        n = 0;
        @(posedge clock_i) go <= 1'b1;
        @(posedge clock_i) go <= 1'b0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
            if (ph && n == 30) begin
                check({9'h0, phase_balance_o, phase_sample_o},
                      11'h002);
            end
            if (ph && n == 90) begin
                check({9'h0, phase_balance_o, phase_sample_o},
                      11'h001);
            end
        end while (busy !== 1'b0 && n < 1000);
        if (n >= 1000) check(11'h7ff, 11'h000);
    endtask : pulse

    // Codes, saturation, flag and the two-rise latency
    task automatic run_stream();
        int c[8] = '{3, 0, 15, 15, 0, 9, 15, 1};
        int f[8] = '{10, 2, 65, 66, 0, 33, 67, 0};
        do_reset();
        for (int i = 0; i < 10; i++) begin
            if (i < 8) set_in(c[i], f[i]);
            pulse(i == 0);
            if (i >= 2) begin
                check({over_range_flag_o, conv_result_bits_o},
                      exp_q[i-2]);
            end
            if (i == 5) begin
                @(posedge clock_i) oe_n_i <= 1'b1;
                #1;
                check({9'h0, conv_result_oe_o, over_range_flag_o},
                      11'h001);
                @(posedge clock_i) oe_n_i <= 1'b0;
                #1;
                check({9'h0, conv_result_oe_o, over_range_flag_o},
                      11'h003);
            end
        end
        check(11'(u_model.got.size()), 11'h008);
        for (int k = 0; k < 8; k++) check(u_model.got[k], exp_q[k]);
        check({10'h0, err_seen}, 11'h000);
    endtask : run_stream

    // Sink stalls: four results fit, later samples are refused
    task automatic run_fifo();
        int n;
        do_reset();
        @(posedge clock_i) stall <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < 6) set_in(i + 1, 4);
            pulse(1'b0);
        end
        check({9'h0, skip_seen, res_valid_o}, 11'h003);
        check(11'(u_model.got.size()), 11'h000);
        @(posedge clock_i) stall <= 1'b0;
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (res_valid_o !== 1'b0 && n < 50);
        check({10'h0, res_valid_o}, 11'h000);
        check(11'(u_model.got.size()), 11'h004);
        for (int k = 0; k < 4; k++) check(u_model.got[k], exp_q[k]);
    endtask : run_fifo

    // A high phase far below the minimum must be flagged
    task automatic run_timing();
        do_reset();
        @(posedge clock_i) hi_cyc <= 8'h0a;
        set_in(2, 2);
        pulse(1'b0);
        check({10'h0, err_seen}, 11'h001);
        @(posedge clock_i) hi_cyc <= 8'h3c;
    endtask : run_timing

    task automatic wrap_up();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        run_stream();
        run_fifo();
        run_timing();
        wrap_up();
    end

    // Whole run is a few thousand cycles; this cuts a hang short
    initial begin
        #500000;
        bad_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        wrap_up();
    end
endmodule : fac_conv_tb_top
